//--- shared/bridge_pm_defs.svh
// Function
// - Bit 20 selects 10 or 16-bit VGA decode
// - Writing one to bit 22 starts hot reset
// - Bit 22 clear means no hot reset driven
// - Downstream port resets its own attached device
// - Upstream port resets all downstream ports together
// - Legacy bits 21 and 23-27 read zero
// - Capability byte reads fixed identifier 01h
// - Next pointer 5Ch upstream, 4Ch downstream
// - Bits 18:16 read 011b, revision 1.2
// - Initialization flag bit 21 defaults zero
// - Aux current bits 24:22 default 111b
// - Bit 25 D1 support defaults one
// - Bit 26 D2 support defaults one
// - Power-event support 31:27 defaults all ones
// - Sideband or EEPROM may replace capability defaults
// - Bridge control sits in upper half of 3Ch
`ifndef BRIDGE_PM_DEFS_SVH
`define BRIDGE_PM_DEFS_SVH

`define OFF_BRIDGE_CTRL   8'h3c
`define OFF_PM_CAP        8'h40

`define BIT_PME_CLOCK     19
`define BIT_VGA16         20
`define BIT_MASTER_ABORT  21
`define BIT_SEC_BUS_RESET 22

`define PM_CAP_ID         8'h01
`define NEXT_PTR_UP       8'h5c
`define NEXT_PTR_DOWN     8'h4c
`define PM_REVISION       3'h3

`define DSI_RESET         1'h0
`define AUX_CURRENT_RESET 3'h7
`define D1_RESET          1'h1
`define D2_RESET          1'h1
`define PME_SUPPORT_RESET 5'h1f

`define INT_LINE_RESET    8'h00
`define INT_PIN_RESET     8'h00
`define BRIDGE_LOW_RESET  4'h0
`define VGA16_RESET       1'h0
`define SBR_RESET         1'h0

`endif

//--- shared/bridge_pm_pkg.sv
package bridge_pm_pkg;

    typedef enum logic [0:0] {
        port_downstream = 1'b0,
        port_upstream   = 1'b1
    } port_role_t;

    typedef struct packed {
        logic       dsi;
        logic [2:0] aux_current;
        logic       d1_support;
        logic       d2_support;
        logic [4:0] pme_support;
    } pm_fields_t;

endpackage : bridge_pm_pkg

//--- shared/pm_cap_if.sv
`timescale 1ns/1ps
interface pm_cap_if;
    bridge_pm_pkg::pm_fields_t fields;
    logic                      lock;

    modport holder (
        output fields,
        input  lock
    );

    modport user (
        input  fields,
        output lock
    );
endinterface : pm_cap_if

//--- hw/pm_cap_override.sv
`timescale 1ns/1ps
`include "bridge_pm_defs.svh"
module pm_cap_override (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       sb_load,
    input  wire logic       sb_dsi,
    input  wire logic [2:0] sb_aux_current,
    input  wire logic       sb_d1_support,
    input  wire logic       sb_d2_support,
    input  wire logic [4:0] sb_pme_support,
    pm_cap_if.holder        pm
);

    bridge_pm_pkg::pm_fields_t fields;
    bridge_pm_pkg::pm_fields_t next_fields;
    bridge_pm_pkg::pm_fields_t loaded;

    // Loads close once software has touched the port
    wire take_load = sb_load & ~pm.lock;

    assign loaded.dsi         = sb_dsi;
    assign loaded.aux_current = sb_aux_current;
    assign loaded.d1_support  = sb_d1_support;
    assign loaded.d2_support  = sb_d2_support;
    assign loaded.pme_support = sb_pme_support;

    assign next_fields = take_load ? loaded : fields;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fields.dsi         <= `DSI_RESET;
            fields.aux_current <= `AUX_CURRENT_RESET;
            fields.d1_support  <= `D1_RESET;
            fields.d2_support  <= `D2_RESET;
            fields.pme_support <= `PME_SUPPORT_RESET;
        end else begin
            fields <= next_fields;
        end
    end

    assign pm.fields = fields;

endmodule : pm_cap_override

//--- hw/bridge_ctrl_pm_cap_regs.sv
`timescale 1ns/1ps
`include "bridge_pm_defs.svh"
module bridge_ctrl_pm_cap_regs #(
    parameter bridge_pm_pkg::port_role_t role           = bridge_pm_pkg::port_upstream,
    parameter int unsigned               num_down_ports = 4
) (
    input  wire logic                      clk,
    input  wire logic                      reset,

    // Configuration access
    input  wire logic                      cfg_valid,
    input  wire logic                      cfg_write,
    input  wire logic [7:0]                cfg_addr,
    input  wire logic [3:0]                cfg_be,
    input  wire logic [31:0]               cfg_wdata,
    output logic      [31:0]               cfg_rdata,
    output logic                           cfg_ack,

    // Sideband or EEPROM default loading
    input  wire logic                      sb_load,
    input  wire logic                      sb_dsi,
    input  wire logic [2:0]                sb_aux_current,
    input  wire logic                      sb_d1_support,
    input  wire logic                      sb_d2_support,
    input  wire logic [4:0]                sb_pme_support,
    output logic                           cap_locked,

    // Bridge control effects
    output logic                           vga_16bit_decode,
    output logic                           hot_reset,
    output logic      [num_down_ports-1:0] port_rst_n
);

    localparam logic [7:0] off_bridge = `OFF_BRIDGE_CTRL;
    localparam logic [7:0] off_pm_cap = `OFF_PM_CAP;
    localparam logic       is_up      = (role == bridge_pm_pkg::port_upstream);

    // Byte-lane merge of a write into a stored byte
    function automatic logic [7:0] merge_byte(
        input logic [7:0] old_value,
        input logic [7:0] new_value,
        input logic       lane
    );
        merge_byte = lane ? new_value : old_value;
    endfunction : merge_byte

    // Reset vector toward downstream devices for a given bus reset level
    function automatic logic [num_down_ports-1:0] reset_vector(
        input logic sbr_level
    );
        logic [num_down_ports-1:0] vec;
        vec = '1;
        if (is_up) begin
            vec = sbr_level ? '0 : '1;
        end else begin
            vec[0] = ~sbr_level;
        end
        reset_vector = vec;
    endfunction : reset_vector

    // Dword index compare, low address bits do not select
    function automatic logic dword_hit(
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        dword_hit = (addr[7:2] == offset[7:2]);
    endfunction : dword_hit

    pm_cap_if pm ();

    pm_cap_override u_override (
        .clk            (clk),
        .reset          (reset),
        .sb_load        (sb_load),
        .sb_dsi         (sb_dsi),
        .sb_aux_current (sb_aux_current),
        .sb_d1_support  (sb_d1_support),
        .sb_d2_support  (sb_d2_support),
        .sb_pme_support (sb_pme_support),
        .pm             (pm.holder)
    );

    // Stored fields of the bridge control dword
    logic [7:0]  int_line;
    logic [3:0]  bridge_low;
    logic        vga16;
    logic        sbr;
    logic        locked;

    logic [7:0]  next_int_line;
    logic [3:0]  next_bridge_low;
    logic        next_vga16;
    logic        next_sbr;
    logic        next_locked;

    // Address decode
    wire hit_bridge = dword_hit(cfg_addr, off_bridge);
    wire hit_pm_cap = dword_hit(cfg_addr, off_pm_cap);
    wire is_read    = cfg_valid & ~cfg_write;
    wire is_write   = cfg_valid & cfg_write;

    // Write strobes per byte lane of the bridge dword
    wire wr_bridge  = is_write & hit_bridge;
    wire wr_lane0   = wr_bridge & cfg_be[0];
    wire wr_lane2   = wr_bridge & cfg_be[2];

    // Lane 1 holds the read-only interrupt pin, lane 3 holds only
    // hardwired and reserved bits, so neither lane has a write path
    wire [7:0] lane2_old = {1'b0, sbr, 1'b0, vga16, bridge_low};
    wire [7:0] lane2_new = merge_byte(lane2_old, cfg_wdata[23:16], wr_lane2);

    assign next_int_line   = merge_byte(int_line, cfg_wdata[7:0], wr_lane0);
    assign next_bridge_low = lane2_new[3:0];
    assign next_vga16      = lane2_new[`BIT_VGA16 - 16];
    assign next_sbr        = lane2_new[`BIT_SEC_BUS_RESET - 16];

    // Writes to the PM capability dword change nothing

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            int_line <= `INT_LINE_RESET;
        end else begin
            int_line <= next_int_line;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bridge_low <= `BRIDGE_LOW_RESET;
        end else begin
            bridge_low <= next_bridge_low;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vga16 <= `VGA16_RESET;
        end else begin
            vga16 <= next_vga16;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sbr <= `SBR_RESET;
        end else begin
            sbr <= next_sbr;
        end
    end

    // Override window closes at the edge after the first configuration access;
    // a load in that same access cycle still lands after software has read
    assign next_locked = locked | cfg_valid;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            locked <= 1'b0;
        end else begin
            locked <= next_locked;
        end
    end

    assign pm.lock = locked;

    // Read image of the bridge control dword
    wire [7:0]  int_pin = `INT_PIN_RESET;
    wire [31:0] bridge_image;

    assign bridge_image[7:0]   = int_line;
    assign bridge_image[15:8]  = int_pin;
    assign bridge_image[19:16] = bridge_low;
    assign bridge_image[20]    = vga16;
    assign bridge_image[21]    = 1'b0;
    assign bridge_image[22]    = sbr;
    assign bridge_image[27:23] = 5'h00;
    assign bridge_image[31:28] = 4'h0;

    // Read image of the PM capability dword
    wire [7:0]  next_ptr = is_up ? `NEXT_PTR_UP : `NEXT_PTR_DOWN;
    wire [31:0] pm_image;

    assign pm_image[7:0]   = `PM_CAP_ID;
    assign pm_image[15:8]  = next_ptr;
    assign pm_image[18:16] = `PM_REVISION;
    assign pm_image[19]    = 1'b0;
    assign pm_image[20]    = 1'b0;
    assign pm_image[21]    = pm.fields.dsi;
    assign pm_image[24:22] = pm.fields.aux_current;
    assign pm_image[25]    = pm.fields.d1_support;
    assign pm_image[26]    = pm.fields.d2_support;
    assign pm_image[31:27] = pm.fields.pme_support;

    // Read select; other offsets belong to neighbouring blocks and
    // read as zero here
    wire [31:0] sel_bridge  = hit_bridge ? bridge_image : 32'h0000_0000;
    wire [31:0] sel_pm_cap  = hit_pm_cap ? pm_image : 32'h0000_0000;
    wire [31:0] read_image  = sel_bridge | sel_pm_cap;

    logic [31:0] next_rdata;
    logic        next_ack;

    // Read data holds between accesses; writes return zero
    assign next_rdata = is_read ? read_image : (cfg_valid ? 32'h0000_0000 : cfg_rdata);
    assign next_ack   = cfg_valid;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_ack <= 1'b0;
        end else begin
            cfg_ack <= next_ack;
        end
    end

    // Effects of the bridge control fields on the port
    logic                      next_hot_reset;
    logic [num_down_ports-1:0] next_port_rst_n;

    assign next_hot_reset  = next_sbr;
    assign next_port_rst_n = reset_vector(next_sbr);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hot_reset <= 1'b0;
        end else begin
            hot_reset <= next_hot_reset;
        end
    end

    // Registered alongside the bit itself, so the pins follow the
    // write at the same edge; upstream moves every port together, downstream only port 0
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            port_rst_n <= '1;
        end else begin
            port_rst_n <= next_port_rst_n;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vga_16bit_decode <= `VGA16_RESET;
        end else begin
            vga_16bit_decode <= next_vga16;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cap_locked <= 1'b0;
        end else begin
            cap_locked <= next_locked;
        end
    end

endmodule : bridge_ctrl_pm_cap_regs

//--- tb/cfg_host_model.sv
`timescale 1ns/1ps
module cfg_host_model (
    input  wire logic        clk,
    output logic             cfg_valid,
    output logic             cfg_write,
    output logic [7:0]       cfg_addr,
    output logic [3:0]       cfg_be,
    output logic [31:0]      cfg_wdata
);
    initial begin
        {cfg_valid, cfg_write, cfg_addr, cfg_be, cfg_wdata} = '0;
    end

    // One-cycle request pulse; a second call leaves one idle cycle
    task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        #1;
        {cfg_valid, cfg_write, cfg_addr, cfg_be, cfg_wdata} = {1'b1, w, a, be, d};
        @(posedge clk);
        #1;
        // Idle bus shows inverse, not stale data
        {cfg_valid, cfg_addr, cfg_wdata} = {1'b0, ~a, ~d};
    endtask : access
endmodule : cfg_host_model

//--- tb/bridge_ctrl_pm_cap_regs_properties.sv
`timescale 1ns/1ps
module bridge_ctrl_pm_cap_regs_properties #(
    parameter bridge_pm_pkg::port_role_t role           = bridge_pm_pkg::port_upstream,
    parameter int unsigned               num_down_ports = 4
) (
    input wire logic                      clk,
    input wire logic                      reset,
    input wire logic                      cfg_valid,
    input wire logic                      cfg_write,
    input wire logic [7:0]                cfg_addr,
    input wire logic [3:0]                cfg_be,
    input wire logic [31:0]               cfg_wdata,
    input wire logic [31:0]               cfg_rdata,
    input wire logic                      cfg_ack,
    input wire logic                      cap_locked,
    input wire logic                      vga_16bit_decode,
    input wire logic                      hot_reset,
    input wire logic [num_down_ports-1:0] port_rst_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire       up       = (role == bridge_pm_pkg::port_upstream);
    wire [7:0] next_ptr = up ? 8'h5c : 8'h4c;
    wire       br_hit   = cfg_valid && cfg_addr[7:2] == 6'h0f;
    wire       pm_rd    = cfg_valid && !cfg_write && cfg_addr[7:2] == 6'h10;
    wire       lane2_wr = br_hit && cfg_write && cfg_be[2];
    wire [num_down_ports-1:0] rst_on = up ? '0 : {{(num_down_ports-1){1'b1}}, 1'b0};

    chk_vga_write: assert property (lane2_wr |=> vga_16bit_decode == $past(cfg_wdata[20]))
        else $error("vga decode not taken from write");
    chk_sbr_write: assert property (lane2_wr |=> hot_reset == $past(cfg_wdata[22]))
        else $error("hot reset not taken from write");
    chk_bridge_hold: assert property (!lane2_wr |=> $stable(hot_reset) && $stable(vga_16bit_decode))
        else $error("bridge output moved without write");
    chk_idle_no_reset: assert property (!hot_reset |-> port_rst_n == '1)
        else $error("port reset without hot reset");
    chk_port_reset_map: assert property (hot_reset |-> port_rst_n == rst_on)
        else $error("port reset pattern wrong");
    chk_cap_const_read: assert property (pm_rd |=> cfg_ack && cfg_rdata[20:0] == {5'h03, next_ptr, 8'h01})
        else $error("capability constants wrong");
    chk_bridge_zero: assert property (br_hit && !cfg_write |=> cfg_rdata[31:23] == 0 && !cfg_rdata[21])
        else $error("bridge fixed bits not zero");
    chk_ack_pulse: assert property (1'b1 |=> cfg_ack == $past(cfg_valid))
        else $error("ack not one cycle after request");
    chk_lock_stays: assert property (cfg_valid || cap_locked |=> cap_locked)
        else $error("capability lock not held");
endmodule : bridge_ctrl_pm_cap_regs_properties

bind bridge_ctrl_pm_cap_regs bridge_ctrl_pm_cap_regs_properties #(.role(role), .num_down_ports(num_down_ports)) u_props (
    .clk(clk), .reset(reset), .cfg_valid(cfg_valid), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .cap_locked(cap_locked),
    .vga_16bit_decode(vga_16bit_decode), .hot_reset(hot_reset), .port_rst_n(port_rst_n));

//--- tb/bridge_ctrl_pm_cap_regs_bench.sv
`timescale 1ns/1ps
module bridge_ctrl_pm_cap_regs_bench;
    logic                      clk = 1'b0;
    logic                      reset = 1'b1;
    logic                      cfg_valid, cfg_write;
    logic [7:0]                cfg_addr;
    logic [3:0]                cfg_be, up_rst_n, dn_rst_n;
    logic [31:0]               cfg_wdata, up_rdata, dn_rdata, ctrl_img, d;
    logic                      up_ack, dn_ack, up_lock, dn_lock, up_vga, dn_vga, up_hot, dn_hot;
    logic                      sb_load = 1'b0, sb_dsi = 1'b0, sb_d1_support = 1'b0, sb_d2_support = 1'b0;
    logic [2:0]                sb_aux_current = 3'h0;
    logic [4:0]                sb_pme_support = 5'h00;
    bridge_pm_pkg::pm_fields_t pm_img;
    logic [63:0]               notes[$];
    logic [63:0]               note;
    int                        errors = 0, checked = 0, seed = 51276;

    always #2.5 clk = ~clk;

    cfg_host_model u_host (.clk(clk), .cfg_valid(cfg_valid), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
    bridge_ctrl_pm_cap_regs #(.role(bridge_pm_pkg::port_upstream), .num_down_ports(4)) u_dut (
        .clk(clk), .reset(reset), .cfg_valid(cfg_valid), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(up_rdata), .cfg_ack(up_ack), .sb_load(sb_load),
        .sb_dsi(sb_dsi), .sb_aux_current(sb_aux_current), .sb_d1_support(sb_d1_support),
        .sb_d2_support(sb_d2_support), .sb_pme_support(sb_pme_support), .cap_locked(up_lock),
        .vga_16bit_decode(up_vga), .hot_reset(up_hot), .port_rst_n(up_rst_n));
    bridge_ctrl_pm_cap_regs #(.role(bridge_pm_pkg::port_downstream), .num_down_ports(4)) u_dut_down (
        .clk(clk), .reset(reset), .cfg_valid(cfg_valid), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(dn_rdata), .cfg_ack(dn_ack), .sb_load(sb_load),
        .sb_dsi(sb_dsi), .sb_aux_current(sb_aux_current), .sb_d1_support(sb_d1_support),
        .sb_d2_support(sb_d2_support), .sb_pme_support(sb_pme_support), .cap_locked(dn_lock),
        .vga_16bit_decode(dn_vga), .hot_reset(dn_hot), .port_rst_n(dn_rst_n));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    function automatic logic [31:0] pm_word(input logic [7:0] ptr);
        return {pm_img.pme_support, pm_img.d2_support, pm_img.d1_support, pm_img.aux_current, pm_img.dsi,
                5'h03, ptr, 8'h01};
    endfunction : pm_word

    task automatic rd(input logic [7:0] a, input logic [31:0] exp_up, input logic [31:0] exp_dn);
        notes.push_back({exp_up, exp_dn});
        u_host.access(1'b0, a, 4'h0, 32'h0000_0000);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
        notes.push_back(64'h0000_0000_0000_0000);
        u_host.access(1'b1, a, be, v);
        if (a == 8'h3c && be[0]) ctrl_img[7:0] = v[7:0];
        if (a == 8'h3c && be[2]) ctrl_img[22:16] = v[22:16] & 7'h5f;
        check("bridge outputs", {ctrl_img[22], ctrl_img[20], {4{~ctrl_img[22]}}, 3'h7, ~ctrl_img[22],
              ctrl_img[22], ctrl_img[20]}, {up_hot, up_vga, up_rst_n, dn_rst_n, dn_hot, dn_vga});
    endtask : wr

    // Loads only take effect before the first access locks the fields
    task automatic sb_pulse(input logic [10:0] v);
        {sb_dsi, sb_aux_current, sb_d1_support, sb_d2_support, sb_pme_support} = v;
        sb_load = 1'b1;
        @(posedge clk);
        #1;
        sb_load = 1'b0;
    endtask : sb_pulse

    task automatic end_of_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Negedge sampling avoids racing the registered answer
    always @(negedge clk) begin
        if (up_ack === 1'b1) begin
            if (notes.size() == 0) begin
                errors++;
                $display("[FAIL] ack expected 0 seen 1");
            end else begin
                note = notes.pop_front();
                check("up rdata", note[63:32], up_rdata);
                check("down rdata", note[31:0], dn_rdata);
                check("down ack", 32'h0000_0001, {31'h0, dn_ack});
            end
        end
    end

    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        $display("[FAIL] run expected done seen timeout");
        end_of_test();
    end

    initial begin
        ctrl_img = 32'h0000_0000;
        pm_img = {1'b0, 3'h7, 1'b1, 1'b1, 5'h1f};
        repeat (6) @(posedge clk);
        #1 reset = 1'b0;
        rd(8'h40, pm_word(8'h5c), pm_word(8'h4c));
        rd(8'h3c, 32'h0000_0000, 32'h0000_0000);
        wr(8'h40, 4'hf, 32'hffff_ffff);
        rd(8'h40, pm_word(8'h5c), pm_word(8'h4c));
        wr(8'h3c, 4'hf, 32'hffff_ffff);
        rd(8'h3c, ctrl_img, ctrl_img);
        rd(8'h44, 32'h0000_0000, 32'h0000_0000);
        for (int i = 0; i < 10; i++) begin
            d = $random(seed);
            wr(8'h3c, d[31:28], d);
            rd(8'h3c, ctrl_img, ctrl_img);
        end
        wr(8'h3c, 4'h4, 32'h0000_0000);
        // Second reset mid-run reopens the sideband window;
        // one more edge lets the monitor take the last write's ack first
        @(posedge clk);
        #1 reset = 1'b1;
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
        ctrl_img = 32'h0000_0000;
        check("lock after reset", 32'h0000_0000, {30'h0, up_lock, dn_lock});
        sb_pulse(11'($random(seed)));
        d = $random(seed);
        sb_pulse(d[10:0]);
        pm_img = d[10:0];
        rd(8'h40, pm_word(8'h5c), pm_word(8'h4c));
        sb_pulse(~d[10:0]);
        rd(8'h40, pm_word(8'h5c), pm_word(8'h4c));
        check("lock", 32'h0000_0003, {30'h0, up_lock, dn_lock});
        rd(8'h3c, 32'h0000_0000, 32'h0000_0000);
        repeat (3) @(posedge clk);
        check("notes left", 32'h0000_0000, notes.size());
        end_of_test();
    end
endmodule : bridge_ctrl_pm_cap_regs_bench
